/* inc/lmf_pkg.sv */
// constants and types shared by the led matrix scan and font controller
package lmf_pkg;

  // ---------------------------------------------------------------
  // register addresses (7-bit command field)
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_NOOP = 7'h00;
  localparam logic [6:0] ADDR_INTENSITY10 = 7'h01;
  localparam logic [6:0] ADDR_INTENSITY32 = 7'h02;
  localparam logic [6:0] ADDR_SCAN_LIMIT = 7'h03;
  localparam logic [6:0] ADDR_CONFIG = 7'h04;
  localparam logic [6:0] ADDR_GLYPH_PORT = 7'h05;
  localparam logic [6:0] ADDR_PLANE0_BASE = 7'h20;
  localparam logic [6:0] ADDR_PLANE1_BASE = 7'h40;
  localparam logic [7:0] CMD_GLYPH_READ = 8'h85;

  // ---------------------------------------------------------------
  // configuration field positions
  // ---------------------------------------------------------------
  localparam int CFG_SHUTDOWN_BIT = 0;
  localparam int CFG_FAST_BIT = 2;
  localparam int CFG_BLINK_EN_BIT = 3;
  localparam int CFG_SYNC_BIT = 4;
  localparam int CFG_CLEAR_BIT = 5;
  localparam int CFG_PHASE_BIT = 7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] DIGIT_RESET = 8'h20;
  localparam logic [7:0] DIGIT_CLEARED = 8'h00;
  localparam logic [7:0] INTENSITY_RESET = 8'h00;

  // ---------------------------------------------------------------
  // glyph ram and pointer
  // ---------------------------------------------------------------
  localparam int GLYPH_ENTRIES = 120;
  localparam logic [7:0] PTR_FIRST = 8'h80;
  localparam logic [7:0] PTR_LAST = 8'hf7;
  localparam logic [2:0] CODE_BANK0 = 3'h0;
  localparam logic [2:0] CODE_BANK1 = 3'h1;
  localparam logic [4:0] BANK1_BASE = 5'h10;
  localparam int CODE_BANK1_TOP = 7;

  // ---------------------------------------------------------------
  // scan and blink timing, in mux clock edges
  // ---------------------------------------------------------------
  localparam int SCAN_DIVIDE = 5600;
  localparam int PAIR_SLOT = SCAN_DIVIDE / 2;
  localparam int PWM_STEPS = 16;
  localparam int PWM_STEP_LEN = PAIR_SLOT / PWM_STEPS;
  localparam logic [3:0] PWM_BLANK_STEP = 4'hf;
  localparam int BLINK_SLOW_HALF = 4000000;
  localparam int BLINK_FAST_HALF = 2000000;
  localparam int FRAME_BITS = 16;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic blink_en;
    logic fast;
    logic shutdown_n;
  } lmf_cfg_t;

  typedef struct packed {
    logic user;
    logic [4:0] glyph;
    logic inverse;
    logic [6:0] code;
  } lmf_char_t;

endpackage

/* src/lmf_ctrl.sv */
// led matrix scan, blink, intensity and user glyph controller
// Notes on behaviour
// R1: clear flag written one clears both planes of all digits at select rise
// R2: config read returns blink phase in top bit, one during plane zero
// R3: codes 0x00-0x0f map glyphs 0-15, 0x10-0x17 map glyphs 16-23
// R4: scan rate is mux clock divided by 5600
// R5: scan and blink timing come only from the mux clock pin
// R6: host shifts config through chain, then toggles select for all devices
// R7: blink pin high during plane zero period, low during plane one
// R8: read command 0x85 returns glyph entry, top bit zero, then advances pointer
// R9: write 0x00-0x7f to glyph port stores entry, then advances pointer
// R10: write 0x80-0xff to glyph port loads pointer instead
// R11: pointer 0x80-0xf6 advances by one after each entry access
// R12: access at pointer 0xf7 wraps pointer to 0x80
// R13: pointer load of 0xf8-0xff sets pointer to 0x80
// R14: digits 0 and 1 driven together, then digits 2 and 3
// R15: one scan limit bit: clear scans first pair, set scans both
// R16: host changes scan limit only during shutdown
// R17: four brightness modulators, one nibble each of two intensity registers
// R18: duty 1/16 to 15/16, at least 1/16 blanked per slot
// R19: no-op register write changes nothing
// R20: blink disabled uses plane zero data only
// R21: blink enabled combines plane bits per half period
// R22: low seven bits select character, top bit selects inverse
// R23: sync flag resets blink counters and scan sequence at select rise
// R24: access framed by one select low period, write applied at select rise
`timescale 1ns/10ps
module lmf_ctrl #(
  parameter int SLOW_HALF = lmf_pkg::BLINK_SLOW_HALF,
  parameter int FAST_HALF = lmf_pkg::BLINK_FAST_HALF
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // serial port pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  // mux clock pin
  input wire logic mux_clock_pin_i,
  // display drive
  output logic [3:0] digit_en_o,
  output lmf_pkg::lmf_char_t [3:0] digit_char_o,
  output logic blink_o
);

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic [1:0] cs_sync_q;
  logic [1:0] sclk_sync_q;
  logic [1:0] din_sync_q;
  logic [1:0] mux_sync_q;
  logic cs_last_q;
  logic sclk_last_q;
  logic mux_last_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cs_sync_q <= 2'h3;
      sclk_sync_q <= 2'h0;
      din_sync_q <= 2'h0;
      mux_sync_q <= 2'h0;
      cs_last_q <= 1'b1;
      sclk_last_q <= 1'b0;
      mux_last_q <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], cs_n_i};
      sclk_sync_q <= {sclk_sync_q[0], sclk_i};
      din_sync_q <= {din_sync_q[0], din_i};
      mux_sync_q <= {mux_sync_q[0], mux_clock_pin_i};
      cs_last_q <= cs_sync_q[1];
      sclk_last_q <= sclk_sync_q[1];
      mux_last_q <= mux_sync_q[1];
    end
  end

  logic cs_low;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic mux_tick;
  assign cs_low = !cs_sync_q[1];
  assign cs_rise = cs_sync_q[1] && !cs_last_q;
  assign sclk_rise = cs_low && sclk_sync_q[1] && !sclk_last_q;
  assign sclk_fall = cs_low && !sclk_sync_q[1] && sclk_last_q;
  assign mux_tick = mux_sync_q[1] && !mux_last_q; // see R5

  // -------------------------------------------------------------
  // serial frame
  // -------------------------------------------------------------
  typedef enum logic [3:0] {
    LMF_IDLE = 4'b0001,
    LMF_ADDR = 4'b0010,
    LMF_DATA = 4'b0100,
    LMF_DONE = 4'b1000
  } lmf_state_t;

  lmf_state_t state_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic [7:0] out_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= LMF_IDLE;
      bit_cnt_q <= 5'h00;
      shift_q <= 16'h0000;
    end else if (!cs_low) begin
      state_q <= LMF_IDLE;
      bit_cnt_q <= 5'h00;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[14:0], din_sync_q[1]};
      bit_cnt_q <= bit_cnt_q + 5'h01;
      unique case (state_q)
        LMF_IDLE: state_q <= LMF_ADDR;
        LMF_ADDR: state_q <= (bit_cnt_q == 5'h07) ? LMF_DATA : LMF_ADDR;
        LMF_DATA: state_q <= (bit_cnt_q == 5'h0f) ? LMF_DONE : LMF_DATA;
        LMF_DONE: state_q <= LMF_DONE;
      endcase
    end
  end

  logic frame_ok;
  logic [7:0] fr_addr;
  logic [7:0] fr_data;
  logic wr_go;
  logic rd_go;
  assign frame_ok = (state_q == LMF_DONE) && (bit_cnt_q == 5'(16));
  assign fr_addr = shift_q[15:8];
  assign fr_data = shift_q[7:0];
  assign wr_go = cs_rise && frame_ok && !fr_addr[7]; // see R24
  assign rd_go = cs_rise && frame_ok && fr_addr[7];

  // -------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------
  lmf_pkg::lmf_cfg_t cfg_q;
  logic [7:0] int10_q;
  logic [7:0] int32_q;
  logic scan_lim_q;
  logic [7:0] plane0_q [4];
  logic [7:0] plane1_q [4];
  logic do_clear;
  logic do_sync;

  assign do_clear = wr_go && (fr_addr[6:0] == lmf_pkg::ADDR_CONFIG) &&
    fr_data[lmf_pkg::CFG_CLEAR_BIT];
  assign do_sync = wr_go && (fr_addr[6:0] == lmf_pkg::ADDR_CONFIG) &&
    fr_data[lmf_pkg::CFG_SYNC_BIT];

  // no-op and unknown addresses take the empty default branch here, see R19
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_q <= '0;
      int10_q <= lmf_pkg::INTENSITY_RESET;
      int32_q <= lmf_pkg::INTENSITY_RESET;
      scan_lim_q <= 1'b0;
    end else if (wr_go) begin
      unique case (fr_addr[6:0])
        lmf_pkg::ADDR_CONFIG: begin
          cfg_q.shutdown_n <= fr_data[lmf_pkg::CFG_SHUTDOWN_BIT];
          cfg_q.fast <= fr_data[lmf_pkg::CFG_FAST_BIT];
          cfg_q.blink_en <= fr_data[lmf_pkg::CFG_BLINK_EN_BIT];
        end
        lmf_pkg::ADDR_INTENSITY10: int10_q <= fr_data; // see R17
        lmf_pkg::ADDR_INTENSITY32: int32_q <= fr_data;
        lmf_pkg::ADDR_SCAN_LIMIT: scan_lim_q <= fr_data[0]; // see R15
        default: begin
        end
      endcase
    end
  end

  generate
    for (genvar g = 0; g < 4; g++) begin : g_digit
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          plane0_q[g] <= lmf_pkg::DIGIT_RESET;
          plane1_q[g] <= lmf_pkg::DIGIT_RESET;
        end else if (do_clear) begin
          plane0_q[g] <= lmf_pkg::DIGIT_CLEARED; // see R1
          plane1_q[g] <= lmf_pkg::DIGIT_CLEARED;
        end else if (wr_go) begin
          if (fr_addr[6:0] == lmf_pkg::ADDR_PLANE0_BASE + 7'(g))
            plane0_q[g] <= fr_data;
          if (fr_addr[6:0] == lmf_pkg::ADDR_PLANE1_BASE + 7'(g))
            plane1_q[g] <= fr_data;
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // glyph ram and pointer
  // -------------------------------------------------------------
  logic [6:0] glyph_ram [lmf_pkg::GLYPH_ENTRIES];
  logic [7:0] ptr_q;
  logic [6:0] ram_idx;
  logic glyph_wr;
  logic glyph_rd;
  logic glyph_ld;

  assign ram_idx = 7'(ptr_q - lmf_pkg::PTR_FIRST);
  assign glyph_wr = wr_go && (fr_addr[6:0] == lmf_pkg::ADDR_GLYPH_PORT) &&
    !fr_data[7]; // see R9
  assign glyph_ld = wr_go && (fr_addr[6:0] == lmf_pkg::ADDR_GLYPH_PORT) &&
    fr_data[7]; // see R10
  assign glyph_rd = rd_go && (fr_addr == lmf_pkg::CMD_GLYPH_READ); // see R8

  function automatic logic [7:0] ptr_next(input logic [7:0] p);
    if (p >= lmf_pkg::PTR_LAST)
      ptr_next = lmf_pkg::PTR_FIRST; // see R12
    else
      ptr_next = p + 8'h01; // see R11
  endfunction

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ptr_q <= lmf_pkg::PTR_FIRST;
    end else if (glyph_ld) begin
      if (fr_data > lmf_pkg::PTR_LAST)
        ptr_q <= lmf_pkg::PTR_FIRST; // see R13
      else
        ptr_q <= fr_data;
    end else if (glyph_wr || glyph_rd) begin
      ptr_q <= ptr_next(ptr_q);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (glyph_wr)
      glyph_ram[ram_idx] <= fr_data[6:0];
  end

  // -------------------------------------------------------------
  // read data and serial out
  // -------------------------------------------------------------
  logic phase_plane0_q;
  logic [7:0] rd_word;

  always_comb begin
    rd_word = 8'h00;
    unique case (shift_q[6:0])
      lmf_pkg::ADDR_CONFIG: begin
        rd_word[lmf_pkg::CFG_PHASE_BIT] = phase_plane0_q; // see R2
        rd_word[lmf_pkg::CFG_BLINK_EN_BIT] = cfg_q.blink_en;
        rd_word[lmf_pkg::CFG_FAST_BIT] = cfg_q.fast;
        rd_word[lmf_pkg::CFG_SHUTDOWN_BIT] = cfg_q.shutdown_n;
      end
      lmf_pkg::ADDR_GLYPH_PORT: rd_word = {1'b0, glyph_ram[ram_idx]};
      lmf_pkg::ADDR_INTENSITY10: rd_word = int10_q;
      lmf_pkg::ADDR_INTENSITY32: rd_word = int32_q;
      lmf_pkg::ADDR_SCAN_LIMIT: rd_word = {7'h00, scan_lim_q};
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (shift_q[6:0] == lmf_pkg::ADDR_PLANE0_BASE + 7'(i))
            rd_word = plane0_q[i];
          if (shift_q[6:0] == lmf_pkg::ADDR_PLANE1_BASE + 7'(i))
            rd_word = plane1_q[i];
        end
      end
    endcase
  end

  // data loaded after the address byte, shifted out on falling edges
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      out_q <= 8'h00;
      dout_o <= 1'b0;
    end else if (state_q == LMF_DATA && bit_cnt_q == 5'h08 && sclk_fall &&
                 shift_q[7]) begin
      out_q <= {rd_word[6:0], 1'b0};
      dout_o <= rd_word[7];
    end else if (sclk_fall && state_q == LMF_DATA) begin
      out_q <= {out_q[6:0], 1'b0};
      dout_o <= out_q[7];
    end else if (!cs_low) begin
      dout_o <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // scan sequence and brightness
  // -------------------------------------------------------------
  logic [11:0] slot_cnt_q;
  logic [3:0] pwm_step_q;
  logic [7:0] step_cnt_q;
  logic pair_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || do_sync) begin
      slot_cnt_q <= 12'h000; // see R23
      step_cnt_q <= 8'h00;
      pwm_step_q <= 4'h0;
      pair_q <= 1'b0;
    end else if (mux_tick) begin
      if (slot_cnt_q == 12'(lmf_pkg::PAIR_SLOT - 1)) begin
        slot_cnt_q <= 12'h000;
        step_cnt_q <= 8'h00;
        pwm_step_q <= 4'h0;
        pair_q <= scan_lim_q && !pair_q; // see R4 R14 R15
      end else begin
        slot_cnt_q <= slot_cnt_q + 12'h001;
        if (step_cnt_q == 8'(lmf_pkg::PWM_STEP_LEN - 1)) begin
          step_cnt_q <= 8'h00;
          pwm_step_q <= pwm_step_q + 4'h1;
        end else begin
          step_cnt_q <= step_cnt_q + 8'h01;
        end
      end
    end
  end

  logic [3:0] nib [4];
  assign nib[0] = int10_q[3:0];
  assign nib[1] = int10_q[7:4];
  assign nib[2] = int32_q[3:0];
  assign nib[3] = int32_q[7:4];

  generate
    for (genvar g = 0; g < 4; g++) begin : g_drive
      always_ff @(posedge core_clk_i) begin
        if (rst_i)
          digit_en_o[g] <= 1'b0;
        else
          digit_en_o[g] <= cfg_q.shutdown_n && (pair_q == 1'(g / 2)) &&
            (pwm_step_q <= nib[g]) &&
            (pwm_step_q != lmf_pkg::PWM_BLANK_STEP); // see R17 R18
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // blink timing
  // -------------------------------------------------------------
  logic [21:0] blink_cnt_q;
  logic [21:0] half_len;
  assign half_len = cfg_q.fast ? 22'(FAST_HALF - 1) : 22'(SLOW_HALF - 1);

  always_ff @(posedge core_clk_i) begin
    if (rst_i || do_sync) begin
      blink_cnt_q <= 22'h000000; // see R23
      phase_plane0_q <= 1'b1;
    end else if (mux_tick) begin
      if (blink_cnt_q >= half_len) begin
        blink_cnt_q <= 22'h000000;
        phase_plane0_q <= !phase_plane0_q; // see R5
      end else begin
        blink_cnt_q <= blink_cnt_q + 22'h000001;
      end
    end
  end

  assign blink_o = phase_plane0_q; // see R7

  // -------------------------------------------------------------
  // character selection
  // -------------------------------------------------------------
  function automatic lmf_pkg::lmf_char_t map_char(input logic [7:0] c);
    map_char = '0;
    map_char.inverse = c[7]; // see R22
    map_char.code = c[6:0];
    if (c[6:4] == lmf_pkg::CODE_BANK0) begin
      map_char.user = 1'b1; // see R3
      map_char.glyph = {1'b0, c[3:0]};
    end else if (c[6:4] == lmf_pkg::CODE_BANK1 &&
                 c[3:0] <= 4'(lmf_pkg::CODE_BANK1_TOP)) begin
      map_char.user = 1'b1;
      map_char.glyph = lmf_pkg::BANK1_BASE + {2'b00, c[2:0]};
    end
  endfunction

  generate
    for (genvar g = 0; g < 4; g++) begin : g_char
      logic [7:0] shown;
      always_comb begin
        if (!cfg_q.blink_en)
          shown = plane0_q[g]; // see R20
        else
          shown = (plane0_q[g] & plane1_q[g]) |
            (plane0_q[g] & {8{phase_plane0_q}}) |
            (plane1_q[g] & {8{!phase_plane0_q}}); // see R21
      end
      always_ff @(posedge core_clk_i) begin
        if (rst_i)
          digit_char_o[g] <= '0;
        else
          digit_char_o[g] <= map_char(shown);
      end
    end
  endgenerate

endmodule // lmf_ctrl

/* testbench/lmf_ctrl_props.sv */
// assertion checker for the led matrix scan and font controller
`timescale 1ns/10ps
module lmf_ctrl_props #(
  parameter int SLOW_HALF = 8,
  parameter int FAST_HALF = 4
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // serial port pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic dout_o,
  // mux clock and display drive
  input wire logic mux_clock_pin_i,
  input wire logic [3:0] digit_en_o,
  input wire lmf_pkg::lmf_char_t [3:0] digit_char_o,
  input wire logic blink_o
);
  localparam int ON_MAX = lmf_pkg::PAIR_SLOT - lmf_pkg::PWM_STEP_LEN + 1;
  logic [3:0] mux_age_q;
  int rise_cnt_q;
  int on_cnt_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // cycles since the last mux clock rise, saturating
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mux_age_q <= 4'hf;
    end else if ($rose(mux_clock_pin_i)) begin
      mux_age_q <= 4'h0;
    end else if (mux_age_q != 4'hf) begin
      mux_age_q <= mux_age_q + 4'h1;
    end
  end

  // mux rises since the blink output last moved
  always_ff @(posedge core_clk_i) begin
    if (rst_i || $changed(blink_o)) begin
      rise_cnt_q <= 0;
    end else if ($rose(mux_clock_pin_i)) begin
      rise_cnt_q <= rise_cnt_q + 1;
    end
  end

  // mux rises while digit 0 is continuously lit
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !digit_en_o[0]) begin
      on_cnt_q <= 0;
    end else if ($rose(mux_clock_pin_i)) begin
      on_cnt_q <= on_cnt_q + 1;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_pairs_apart: assert property (
    !((|digit_en_o[1:0]) && (|digit_en_o[3:2])))
    else $error("both digit pairs driven at once");
  chk_blank_gap: assert property (on_cnt_q <= ON_MAX)
    else $error("digit lit longer than fifteen steps");
  chk_blink_src: assert property (
    $fell(blink_o) |-> mux_age_q <= 4'h8)
    else $error("blink moved without a mux clock edge");
  chk_blink_half: assert property (
    $fell(blink_o) |-> rise_cnt_q >= FAST_HALF - 2)
    else $error("blink half period too short");
  chk_dout_quiet: assert property (
    cs_n_i [*6] |-> !dout_o)
    else $error("serial out active while deselected");
  chk_user_bank: assert property (
    digit_char_o[0].user |-> ((digit_char_o[0].code[6:4] == 3'h0) ||
    (digit_char_o[0].code[6:3] == 4'h2)) &&
    (digit_char_o[0].glyph == digit_char_o[0].code[4:0]))
    else $error("user glyph selected by wrong code");
  chk_user_hit: assert property (
    !$past(rst_i) && (digit_char_o[0].code[6:3] == 4'h2)
    |-> digit_char_o[0].user)
    else $error("upper user glyph code not mapped");
  chk_char_frame: assert property (
    !cs_n_i && !$past(cs_n_i, 6) && $stable(blink_o) &&
    (blink_o == $past(blink_o, 3)) |-> $stable(digit_char_o))
    else $error("digit changed inside a frame");
endmodule // lmf_ctrl_props

bind lmf_ctrl lmf_ctrl_props #(
  .SLOW_HALF(SLOW_HALF),
  .FAST_HALF(FAST_HALF)
) props (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
  .sclk_i(sclk_i), .din_i(din_i), .dout_o(dout_o),
  .mux_clock_pin_i(mux_clock_pin_i), .digit_en_o(digit_en_o),
  .digit_char_o(digit_char_o), .blink_o(blink_o)
);

/* testbench/lmf_host_model.sv */
// host model driving the chip select framed serial port
`timescale 1ns/10ps
module lmf_host_model (
  // clock
  input wire logic clk_i,
  // serial port
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o,
  input wire logic dout_i
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end

  // one frame: address byte then data byte, msb first
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk_i);
    #1 cs_n_o = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      din_o = tx[k];
      repeat (6) @(posedge clk_i);
      if (k < 8) begin
        rx[k] = dout_i;
      end
      #1 sclk_o = 1'b1;
      repeat (6) @(posedge clk_i);
      #1 sclk_o = 1'b0;
    end
    repeat (6) @(posedge clk_i);
    #1 cs_n_o = 1'b1;
    din_o = ~din_o;
    repeat (8) @(posedge clk_i);
    #1;
  endtask
endmodule // lmf_host_model

/* testbench/tb_lmf_ctrl.sv */
// self-checking testbench for the led matrix scan and font controller
`timescale 1ns/10ps
module tb_lmf_ctrl;
  localparam int SH = 8;
  localparam int FH = 4;
  logic core_clk_i;
  logic rst_i;
  logic mux_pin;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic blink;
  logic [3:0] en;
  logic [3:0] seen;
  logic seen_clr;
  lmf_pkg::lmf_char_t [3:0] chars;
  int bad_count;
  int tests_run;

  lmf_ctrl #(.SLOW_HALF(SH), .FAST_HALF(FH)) uut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .din_i(din), .dout_o(dout), .mux_clock_pin_i(mux_pin),
    .digit_en_o(en), .digit_char_o(chars), .blink_o(blink));

  lmf_host_model host (.clk_i(core_clk_i), .cs_n_o(cs_n), .sclk_o(sclk),
    .din_o(din), .dout_i(dout));

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) seen <= seen_clr ? 4'h0 : (seen | en);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({15'h0, got}, {15'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer({a, d}, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    host.xfer({a, 8'h00}, d);
  endtask

  task automatic pulse_mux(input int n);
    repeat (n) begin
      repeat (2) @(posedge core_clk_i);
      #1 mux_pin = 1'b1;
      repeat (2) @(posedge core_clk_i);
      #1 mux_pin = 1'b0;
    end
    repeat (8) @(posedge core_clk_i);
    #1;
  endtask

  task automatic clr_seen;
    seen_clr = 1'b1;
    @(posedge core_clk_i);
    #1 seen_clr = 1'b0;
  endtask

  function automatic logic [15:0] ch_of(input lmf_pkg::lmf_char_t c);
    return {7'h0, c.user, c.inverse, c.code};
  endfunction

  function automatic logic [15:0] ch_exp(input logic [7:0] c);
    logic user;
    user = (c[6:4] == 3'h0) || (c[6:3] == 4'h2);
    return {7'h0, user, c[7], c[6:0]};
  endfunction

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] r;
    cmp_bit(blink, 1'b1);
    rd(8'h84, r);
    cmp_bit(r[7], 1'b1);
    wr(8'h04, 8'h01);
    for (int d = 0; d < 4; d++) begin
      cmp_val(ch_of(chars[d]), ch_exp(8'h20));
    end
  endtask

  task automatic t_font;
    logic [7:0] r;
    logic [7:0] ex [3] = '{8'h11, 8'h22, 8'h7f};
    wr(8'h05, 8'hf6);
    foreach (ex[i]) begin
      wr(8'h05, ex[i]);
    end
    wr(8'h05, 8'hf6);
    foreach (ex[i]) begin
      rd(lmf_pkg::CMD_GLYPH_READ, r);
      cmp_val({8'h0, r}, {8'h0, ex[i]});
    end
    wr(8'h05, 8'hfc);
    rd(lmf_pkg::CMD_GLYPH_READ, r);
    cmp_val({8'h0, r}, 16'h007f);
  endtask

  task automatic t_chars;
    logic [7:0] cd [6] = '{8'h00, 8'h0f, 8'h10, 8'h17, 8'h18, 8'hc1};
    foreach (cd[i]) begin
      wr(8'h20, cd[i]);
      cmp_val(ch_of(chars[0]), ch_exp(cd[i]));
      if (cd[i][6:3] <= 4'h2) begin
        cmp_val({11'h0, chars[0].glyph}, {11'h0, cd[i][4:0]});
      end
    end
    wr(8'h40, 8'h55);
    cmp_val(ch_of(chars[0]), ch_exp(8'hc1));
    wr(8'h00, 8'hff);
    cmp_val(ch_of(chars[0]), ch_exp(8'hc1));
    wr(8'h04, 8'h21);
    for (int d = 0; d < 4; d++) begin
      cmp_val(ch_of(chars[d]), ch_exp(8'h00));
    end
  endtask

  task automatic t_blink;
    logic [7:0] r;
    wr(8'h20, 8'h0f);
    wr(8'h40, 8'hf0);
    for (int f = 0; f < 2; f++) begin
      wr(8'h04, (f != 0) ? 8'h1d : 8'h19);
      cmp_bit(blink, 1'b1);
      rd(8'h84, r);
      cmp_bit(r[7], 1'b1);
      cmp_val(ch_of(chars[0]), ch_exp(8'h0f));
      pulse_mux((f != 0) ? FH : SH);
      cmp_bit(blink, 1'b0);
      rd(8'h84, r);
      cmp_bit(r[7], 1'b0);
      cmp_val(ch_of(chars[0]), ch_exp(8'hf0));
    end
  endtask

  task automatic t_scan;
    wr(8'h01, 8'hff);
    wr(8'h02, 8'hff);
    for (int s = 0; s < 2; s++) begin
      wr(8'h04, 8'h00);
      wr(8'h03, s[7:0]);
      clr_seen();
      pulse_mux(300);
      cmp_val({12'h0, seen}, 16'h0000);
      wr(8'h04, 8'h01);
      clr_seen();
      pulse_mux(6000);
      cmp_val({12'h0, seen}, (s != 0) ? 16'h000f : 16'h0003);
    end
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    bad_count = 0;
    tests_run = 0;
    rst_i = 1'b1;
    mux_pin = 1'b0;
    seen_clr = 1'b1;
    repeat (10) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    t_reset();
    t_font();
    t_chars();
    t_blink();
    t_scan();
    close_out();
  end

  initial begin
    repeat (90000) @(posedge core_clk_i);
    bad_count++;
    close_out();
  end
endmodule // tb_lmf_ctrl
